//--- rtl/clc_cache_ctrl.sv
`timescale 1ns/1ps
module clc_cache_ctrl
(
    input  wire logic                     i_core_clk,
    input  wire logic                     i_rst,
    input  wire logic [clc_pkg::ADR_W-1:0] i_reg_addr,
    input  wire logic [15:0]              i_reg_wdata,
    input  wire logic                     i_reg_wr,
    input  wire logic                     i_reg_rd,
    output logic [15:0]                   o_reg_rdata,
    output logic                          o_fetch_req,
    output logic [15:0]                   o_fetch_addr,
    input  wire logic                     i_pdb_valid,
    input  wire logic [15:0]              i_program_data_bus,
    input  wire logic [3:0]               i_wait_states,
    output clc_pkg::clc_exec_type         o_exec,
    output logic                          o_exec_valid,
    input  wire logic [15:0]              i_irq_events,
    input  wire logic [15:0]              i_irq_clear,
    output logic                          o_irq_req,
    output logic                          o_loop_active,
    input  wire clc_pkg::clc_flags_type   i_unit_flags,
    input  wire logic                     i_corr_busy,
    input  wire logic                     i_ext_mem_strap,
    input  wire logic                     i_wake,
    output logic                          o_standby_request,
    output logic [1:0]                    o_map_sel
);
    import clc_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    clc_mode_type mode_r;
    logic [15:0]  cache_r [CACHE_DEPTH];
    logic [3:0]   idx_r;
    logic [3:0]   len_r;
    logic [3:0]   cached_len_r;
    logic [3:0]   fcnt_r;
    logic [6:0]   cloop_r;
    logic [15:0]  dec_word_r;
    logic         dec_valid_r;
    logic         outstanding_r;
    logic [15:0]  pc_r;
    logic         fetch_req_r;
    logic [15:0]  fetch_addr_r;
    logic [4:0]   exec_cnt_r;
    clc_exec_type exec_r;
    logic         exec_valid_r;
    logic [15:0]  inc_r;
    logic [15:0]  ins_r;
    logic         standby_r;
    logic         lowmap_r;
    logic         strap_s1_r;
    logic         strap_s2_r;
    logic         strap_r;
    logic [1:0]   map_sel_r;
    logic         irq_req_r;
    logic         loop_active_r;
    logic [15:0]  rdata_r;
    logic [15:0]  rdata_nxt;

    logic [15:0]  cur_word;
    logic         cur_valid;
    logic         adv;
    logic         is_rpt;
    logic [3:0]   fld_n;
    logic [6:0]   fld_k;
    logic         at_last;
    logic         last_pass;
    logic         can_fetch;
    logic [4:0]   cyc_base;
    logic [4:0]   cyc_nxt;

    // ------------------------------------------------------------
    // decode stage
    // ------------------------------------------------------------
    assign cur_word  = (mode_r == MODE_LOOP) ? cache_r[idx_r] : dec_word_r;
    assign cur_valid = (mode_r == MODE_LOOP) || dec_valid_r;
    assign adv       = cur_valid && (exec_cnt_r <= 5'h01);
    assign is_rpt    = (mode_r == MODE_RUN)
                       && (cur_word[OPC_MSB:OPC_LSB] == REPEAT_OPC);
    assign fld_n     = cur_word[LEN_MSB:LEN_LSB];
    assign fld_k     = cur_word[CNT_MSB:CNT_LSB];
    assign at_last   = (idx_r == len_r - 4'h1);
    assign last_pass = (cloop_r <= 7'h01);

    always_comb
    begin
        cyc_base = CYC_OUT;
        if (mode_r == MODE_FIRST && at_last)
        begin
            cyc_base = CYC_FIRST_LAST;
        end
        else if (mode_r == MODE_LOOP)
        begin
            cyc_base = (last_pass && at_last) ? CYC_OUT : CYC_IN;
        end
        cyc_nxt = cyc_base + {1'b0, i_wait_states};
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            dec_valid_r <= 1'b0;
            dec_word_r  <= 16'h0000;
        end
        else if (outstanding_r && i_pdb_valid)
        begin
            dec_valid_r <= 1'b1;
            dec_word_r  <= i_program_data_bus;
        end
        else if (adv)
        begin
            dec_valid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // cache storage
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < CACHE_DEPTH; gi++)
        begin : g_cache
            always_ff @(posedge i_core_clk)
            begin
                if (i_rst)
                begin
                    cache_r[gi] <= 16'h0000;
                end
                else if (adv && mode_r == MODE_FIRST
                         && idx_r == 4'(gi))
                begin
                    cache_r[gi] <= dec_word_r;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // loop sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            mode_r       <= MODE_RUN;
            idx_r        <= 4'h0;
            len_r        <= 4'h0;
            cached_len_r <= 4'h0;
        end
        else if (adv && is_rpt)
        begin
            idx_r <= 4'h0;
            if (fld_n != 4'h0)
            begin
                mode_r       <= MODE_FIRST;
                len_r        <= fld_n;
                cached_len_r <= fld_n;
            end
            else if (cached_len_r != 4'h0)
            begin
                mode_r <= MODE_LOOP;
                len_r  <= cached_len_r;
            end
        end
        else if (adv && mode_r != MODE_RUN)
        begin
            if (!at_last)
            begin
                idx_r <= idx_r + 4'h1;
            end
            else
            begin
                idx_r  <= 4'h0;
                mode_r <= last_pass ? MODE_RUN : MODE_LOOP;
            end
        end
    end

    // ------------------------------------------------------------
    // loop count register
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            cloop_r <= CLOOP_RST;
        end
        else if (adv && is_rpt)
        begin
            if (fld_k != 7'h00)
            begin
                cloop_r <= fld_k;
            end
        end
        else if (adv && mode_r != MODE_RUN && at_last)
        begin
            cloop_r <= last_pass ? 7'h00 : cloop_r - 7'h01;
        end
        else if (i_reg_wr && i_reg_addr == ADR_CLOOP)
        begin
            cloop_r <= i_reg_wdata[6:0];
        end
    end

    // ------------------------------------------------------------
    // fetch stage
    // ------------------------------------------------------------
    assign can_fetch = !outstanding_r && (!dec_valid_r || adv)
                       && !standby_r && !(dec_valid_r && is_rpt)
                       && ((mode_r == MODE_RUN)
                           || (mode_r == MODE_FIRST && fcnt_r < len_r));

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            fetch_req_r   <= 1'b0;
            fetch_addr_r  <= 16'h0000;
            pc_r          <= 16'h0000;
            outstanding_r <= 1'b0;
            fcnt_r        <= 4'h0;
        end
        else
        begin
            fetch_req_r <= can_fetch;
            if (can_fetch)
            begin
                fetch_addr_r  <= pc_r;
                pc_r          <= pc_r + 16'h0001;
                outstanding_r <= 1'b1;
            end
            else if (i_pdb_valid)
            begin
                outstanding_r <= 1'b0;
            end
            if (adv && is_rpt)
            begin
                fcnt_r <= 4'h0;
            end
            else if (can_fetch && mode_r == MODE_FIRST)
            begin
                fcnt_r <= fcnt_r + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // execute stage
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            exec_valid_r <= 1'b0;
            exec_r       <= '0;
            exec_cnt_r   <= 5'h00;
        end
        else if (adv)
        begin
            exec_valid_r      <= 1'b1;
            exec_r.word       <= cur_word;
            exec_r.from_cache <= (mode_r == MODE_LOOP);
            exec_r.cycles     <= cyc_nxt;
            exec_cnt_r        <= cyc_nxt;
        end
        else
        begin
            exec_valid_r <= 1'b0;
            if (exec_cnt_r != 5'h00)
            begin
                exec_cnt_r <= exec_cnt_r - 5'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt enable and flags
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            inc_r <= INC_RST;
        end
        else if (i_reg_wr && i_reg_addr == ADR_INC)
        begin
            inc_r <= i_reg_wdata & INT_MASK;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            ins_r <= INS_RST;
        end
        else
        begin
            ins_r <= ((ins_r & ~i_irq_clear) | i_irq_events) & INT_MASK;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            irq_req_r     <= 1'b0;
            loop_active_r <= 1'b0;
        end
        else
        begin
            irq_req_r     <= (|(ins_r & inc_r)) && (mode_r == MODE_RUN);
            loop_active_r <= (mode_r != MODE_RUN);
        end
    end

    // ------------------------------------------------------------
    // processor flags and memory map
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            standby_r <= 1'b0;
            lowmap_r  <= 1'b0;
        end
        else if (i_reg_wr && i_reg_addr == ADR_ALF)
        begin
            standby_r <= i_reg_wdata[ALF_STANDBY];
            lowmap_r  <= i_reg_wdata[ALF_LOWMAP];
        end
        else if (i_wake)
        begin
            standby_r <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        strap_s1_r <= i_ext_mem_strap;
        strap_s2_r <= strap_s1_r;
        if (i_rst)
        begin
            strap_r   <= strap_s2_r;
            map_sel_r <= 2'b00;
        end
        else
        begin
            map_sel_r <= {lowmap_r, strap_r};
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = 16'h0000;
        unique case (i_reg_addr)
            ADR_INC:   rdata_nxt = inc_r;
            ADR_INS:   rdata_nxt = ins_r;
            ADR_ALF:
            begin
                rdata_nxt[ALF_STANDBY] = standby_r;
                rdata_nxt[ALF_LOWMAP]  = lowmap_r;
                rdata_nxt[ALF_BUSY]    = USE_EXTENDED & i_corr_busy;
                rdata_nxt[7:0]         = i_unit_flags;
            end
            ADR_CLOOP: rdata_nxt = {9'h000, cloop_r};
            ADR_STAT:  rdata_nxt = {8'h00, cached_len_r, idx_r[1:0], mode_r};
            default:   rdata_nxt = 16'h0000;
        endcase
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            rdata_r <= 16'h0000;
        end
        else
        begin
            rdata_r <= i_reg_rd ? rdata_nxt : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_reg_rdata       = rdata_r;
    assign o_fetch_req       = fetch_req_r;
    assign o_fetch_addr      = fetch_addr_r;
    assign o_exec            = exec_r;
    assign o_exec_valid      = exec_valid_r;
    assign o_irq_req         = irq_req_r;
    assign o_loop_active     = loop_active_r;
    assign o_standby_request = standby_r;
    assign o_map_sel         = map_sel_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_irq_held_loop: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_irq_req |-> $past(mode_r) == MODE_RUN)
        else $error("interrupt raised during cache loop");

    a_count_load: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (adv && is_rpt && fld_k != 7'h00) |=> cloop_r == $past(fld_k))
        else $error("immediate count not loaded");

    a_first_last_two: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (adv && mode_r == MODE_FIRST && at_last)
        |=> o_exec_valid && o_exec.cycles == CYC_FIRST_LAST
            + {1'b0, $past(i_wait_states)})
        else $error("first pass last word timing wrong");

    a_mid_in_cache: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (adv && mode_r == MODE_LOOP && !(last_pass && at_last))
        |=> o_exec.from_cache && o_exec.cycles == CYC_IN
            + {1'b0, $past(i_wait_states)})
        else $error("in-cache timing wrong");

    a_last_out_cache: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (adv && mode_r == MODE_LOOP && last_pass && at_last)
        |=> o_exec.cycles == CYC_OUT + {1'b0, $past(i_wait_states)}
            ##1 mode_r == MODE_RUN)
        else $error("last pass final timing wrong");

    a_no_fetch_loop: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_fetch_req |-> $past(mode_r) != MODE_LOOP)
        else $error("fetch while replaying cache");

    a_end_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (mode_r == MODE_RUN && $past(mode_r) != MODE_RUN) |-> cloop_r == 7'h00)
        else $error("loop count not zero at loop end");

    a_pipe_fill: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (outstanding_r && i_pdb_valid && !can_fetch)
        |=> dec_valid_r && dec_word_r == $past(i_program_data_bus))
        else $error("fetched word not in decode");

endmodule

//--- rtl/clc_pkg.sv
// Contract
// - repeat word: opcode bits 15..11 = 01110, length 10..7, count 6..0.
// - count field 1 to 127 is the number of passes over the block.
// - length field picks 1 to 15 following words for the cache.
// - first pass fetched, normal timing, last word of block takes two cycles.
// - middle passes come from the cache with in-cache timing.
// - last pass from cache, but its last word takes out-of-cache timing.
// - external access adds the segment's wait-states to the cycle count.
// - immediate count loads the loop count register; it drops each pass.
// - interrupt requests are held off while a cache loop runs.
// - redo form replays cached words without fetching from memory.
// - three stage fetch, decode, execute pipeline hidden from program.
// - words arrive on the program data bus and are decoded in hardware.
// - enable and flag registers share layout; ext bits 13, 12.
// - flag register bit 15 puts the processor into standby.
// - flag register bit 14 with the memory strap selects the memory map.
// - flag register bit 8 shows coprocessor busy, else reserved.
// - bits 7..4: not-minus-one, minus-one, even and odd parity.
// - bits 3..0: some false, some true, all false, all true.
package clc_pkg;

    // ------------------------------------------------------------
    // instruction fields
    // ------------------------------------------------------------
    localparam int unsigned OPC_MSB     = 15;
    localparam int unsigned OPC_LSB     = 11;
    localparam int unsigned LEN_MSB     = 10;
    localparam int unsigned LEN_LSB     = 7;
    localparam int unsigned CNT_MSB     = 6;
    localparam int unsigned CNT_LSB     = 0;
    localparam logic [4:0]  REPEAT_OPC  = 5'h0e;
    localparam int unsigned CACHE_DEPTH = 15;

    // ------------------------------------------------------------
    // cycle counts
    // ------------------------------------------------------------
    localparam logic [4:0] CYC_IN         = 5'h01;
    localparam logic [4:0] CYC_OUT        = 5'h02;
    localparam logic [4:0] CYC_FIRST_LAST = 5'h02;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int unsigned ADR_W     = 3;
    localparam logic [2:0]  ADR_INC   = 3'h0;
    localparam logic [2:0]  ADR_INS   = 3'h1;
    localparam logic [2:0]  ADR_ALF   = 3'h2;
    localparam logic [2:0]  ADR_CLOOP = 3'h3;
    localparam logic [2:0]  ADR_STAT  = 3'h4;

    localparam int unsigned ALF_STANDBY = 15;
    localparam int unsigned ALF_LOWMAP  = 14;
    localparam int unsigned ALF_BUSY    = 8;

    localparam logic        USE_EXTENDED  = 1'b1;
    localparam logic [15:0] INT_MASK_BAS  = 16'h873f;
    localparam logic [15:0] INT_MASK_EXT  = 16'hb73f;
    localparam logic [15:0] INT_MASK      =
        USE_EXTENDED ? INT_MASK_EXT : INT_MASK_BAS;

    localparam logic [15:0] INC_RST   = 16'h0000;
    localparam logic [15:0] INS_RST   = 16'h0000;
    localparam logic [6:0]  CLOOP_RST = 7'h00;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_RUN   = 2'b00,
        MODE_FIRST = 2'b01,
        MODE_LOOP  = 2'b10
    } clc_mode_type;

    typedef struct packed {
        logic [15:0] word;
        logic        from_cache;
        logic [4:0]  cycles;
    } clc_exec_type;

    typedef struct packed {
        logic not_minus_one_flag;
        logic minus_one_flag;
        logic even_parity;
        logic odd_parity;
        logic some_false;
        logic some_true;
        logic all_false;
        logic all_true;
    } clc_flags_type;

endpackage

//--- tb/clc_pmem_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// program memory, one answer per request, fast or slow
// ------------------------------------------------------------
module clc_pmem_model
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_slow,
    input  wire logic        i_fetch_req,
    input  wire logic [15:0] i_fetch_addr,
    output logic             o_pdb_valid,
    output logic [15:0]      o_program_data_bus
);
    logic [15:0] mem [0:63];
    logic [2:0]  wait_r;
    logic        pend_r;

    always_ff @(posedge i_core_clk)
    begin
        o_pdb_valid        <= 1'b0;
        o_program_data_bus <= ~o_program_data_bus;
        if (i_rst)
        begin
            pend_r             <= 1'b0;
            o_program_data_bus <= 16'h5a5a;
        end
        else if (i_fetch_req)
        begin
            pend_r <= 1'b1;
            wait_r <= i_slow ? 3'h4 : 3'h0;
        end
        else if (pend_r && wait_r != 3'h0)
            wait_r <= wait_r - 3'h1;
        else if (pend_r)
        begin
            pend_r             <= 1'b0;
            o_pdb_valid        <= 1'b1;
            o_program_data_bus <= mem[i_fetch_addr[5:0]];
        end
    end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// bench for the cache loop and control unit
// ------------------------------------------------------------
module tb_top;
    import clc_pkg::*;
    logic          clk = 1'b0;
    logic          rst = 1'b1;
    logic          wr, rd, pv, req, xv, irq, la, busy, strap, wake, sb, slow;
    logic [2:0]    addr;
    logic [15:0]   wd, rdat, fa, pdb, ev, clr;
    logic [3:0]    ws;
    logic [1:0]    ms;
    clc_flags_type uf;
    clc_exec_type  ex;
    clc_exec_type  q[$];
    clc_exec_type  eq[$];
    int            errors, checks;

    always #50 clk = ~clk;

    clc_cache_ctrl u_clc_cache_ctrl (.i_core_clk(clk), .i_rst(rst),
        .i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdat), .o_fetch_req(req), .o_fetch_addr(fa),
        .i_pdb_valid(pv), .i_program_data_bus(pdb), .i_wait_states(ws),
        .o_exec(ex), .o_exec_valid(xv), .i_irq_events(ev),
        .i_irq_clear(clr), .o_irq_req(irq), .o_loop_active(la),
        .i_unit_flags(uf), .i_corr_busy(busy), .i_ext_mem_strap(strap),
        .i_wake(wake), .o_standby_request(sb), .o_map_sel(ms));

    clc_pmem_model u_clc_pmem_model (.i_core_clk(clk), .i_rst(rst),
        .i_slow(slow), .i_fetch_req(req), .i_fetch_addr(fa),
        .o_pdb_valid(pv), .o_program_data_bus(pdb));

    always @(negedge clk)
        if (rst)
            q.delete();
        else if (xv === 1'b1)
            q.push_back(ex);

    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask

    task give_verdict;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task wreg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wd   <= d;
        wr   <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task rreg(input string n, input logic [2:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(n, e, rdat);
    endtask

    task do_reset(input logic s);
        @(posedge clk);
        rst   <= 1'b1;
        strap <= s;
        for (int i = 0; i < 64; i++)
            u_clc_pmem_model.mem[i] = 16'(16'h1000 + i);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
    endtask

    task push(input logic [15:0] w, input logic fc, input logic [4:0] cy);
        clc_exec_type e;
        e.word       = w;
        e.from_cache = fc;
        e.cycles     = cy;
        eq.push_back(e);
    endtask

    task regs_scn;
        uf   <= clc_flags_type'(8'ha5);
        busy <= 1'b1;
        do_reset(1'b1);
        rreg("inc", ADR_INC, INC_RST);
        rreg("ins", ADR_INS, INS_RST);
        wreg(ADR_INC, 16'hffff);
        rreg("inc mask", ADR_INC, INT_MASK);
        @(posedge clk);
        ev <= 16'hffff;
        @(posedge clk);
        ev <= 16'h0000;
        wreg(ADR_INS, 16'h0000);
        rreg("ins", ADR_INS, INT_MASK);
        @(posedge clk);
        clr <= 16'hffff;
        @(posedge clk);
        clr <= 16'h0000;
        rreg("ins clear", ADR_INS, 16'h0000);
        wreg(ADR_CLOOP, 16'hffff);
        rreg("cloop", ADR_CLOOP, 16'h007f);
        wreg(ADR_ALF, 16'hffff);
        rreg("alf", ADR_ALF, 16'hc1a5);
        chk("standby", 32'h1, 32'(sb));
        chk("map", 32'h3, 32'(ms));
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        rreg("alf wake", ADR_ALF, 16'h41a5);
        rreg("unmapped", 3'h7, 16'h0000);
    endtask

    task automatic run_do(input logic [3:0] n, input logic [6:0] kf,
                          input logic [6:0] cl, input logic [6:0] rk,
                          input logic [3:0] w, input logic sl);
        int k, j, c, nx;
        logic seen, act, irqs;
        logic [4:0] wc, b;
        wc = {1'b0, w};
        k  = (kf != 0) ? kf : ((cl != 0) ? cl : 1);
        eq.delete();
        do_reset(1'b0);
        ws   <= w;
        slow <= sl;
        // blocks hold plain data words only
        u_clc_pmem_model.mem[0] = {REPEAT_OPC, n, kf};
        if (rk != 0)
            u_clc_pmem_model.mem[n + 1] = {REPEAT_OPC, 4'h0, rk};
        if (kf == 0)
            wreg(ADR_CLOOP, {9'h000, cl});
        wreg(ADR_INC, 16'h0001);
        push({REPEAT_OPC, n, kf}, 1'b0, CYC_OUT + wc);
        for (int p = 1; p <= k; p++)
            for (int i = 0; i < n; i++)
            begin
                b = (p == 1) ? ((i == n - 1) ? CYC_FIRST_LAST : CYC_OUT)
                  : ((p == k && i == n - 1) ? CYC_OUT : CYC_IN);
                push(16'(16'h1001 + i), p > 1, b + wc);
            end
        nx = n + 1;
        if (rk != 0)
        begin
            push({REPEAT_OPC, 4'h0, rk}, 1'b0, CYC_OUT + wc);
            for (int p = 0; p < rk; p++)
                for (int i = 0; i < n; i++)
                    push(16'(16'h1001 + i), 1'b1, 5'h1f);
            nx = n + 2;
        end
        push(16'(16'h1000 + nx), 1'b0, CYC_OUT + wc);
        seen = 1'b0;
        c    = 0;
        for (j = 0; j < 5000 && q.size() < eq.size(); j++)
        begin
            @(negedge clk);
            act  = la;
            irqs = irq;
            @(posedge clk);
            ev <= (act === 1'b1 && !seen) ? 16'h0001 : 16'h0000;
            if (act === 1'b1)
                seen = 1'b1;
            if (seen)
                c++;
            if (c == 4 && act === 1'b1)
                chk("irq held", 32'h0, 32'(irqs));
        end
        chk("exec count", eq.size(), q.size());
        if (q.size() < eq.size())
            give_verdict;
        for (int i = 0; i < eq.size(); i++)
            if (eq[i].cycles == 5'h1f)
                chk("exec", eq[i][21:5], q[i][21:5]);
            else
                chk("exec", eq[i], q[i]);
        chk("loop seen", 32'h1, 32'(seen));
        rreg("cloop end", ADR_CLOOP, 16'h0000);
        chk("irq after", 32'h1, 32'(irq));
    endtask

    initial
    begin
        {wr, rd, busy, strap, wake, slow} = 6'h00;
        addr   = 3'h0;
        wd     = 16'h0000;
        ev     = 16'h0000;
        clr    = 16'h0000;
        ws     = 4'h0;
        uf     = clc_flags_type'(8'h00);
        errors = 0;
        checks = 0;
        regs_scn;
        run_do(4'd2, 7'd3, 7'd0, 7'd0, 4'd0, 1'b0);
        run_do(4'd15, 7'd1, 7'd0, 7'd0, 4'd3, 1'b1);
        run_do(4'd1, 7'd127, 7'd0, 7'd0, 4'd0, 1'b0);
        run_do(4'd1, 7'd0, 7'd4, 7'd0, 4'd0, 1'b0);
        run_do(4'd2, 7'd2, 7'd0, 7'd3, 4'd0, 1'b0);
        give_verdict;
    end
endmodule
